// File: common/aio_pkg.sv
// constants, types and shared decoding for the analog i/o scan and code map block
package aio_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS   = 10;                       // mclk period, 100 MHz
    localparam int IN_CONV_TIME_NS = 500000;                   // 0.5 ms per input channel
    localparam int IN_CONV_CYC     = (IN_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IN_BASIC_CYC    = 40000;                    // basic part of a slot
    localparam int OUT_CONV_CYC    = 1000;                     // output conversion time

    // word layout
    localparam int WORD_BITS = 16;                             // analog value word
    localparam int SIGN_BIT  = 15;                             // sign position
    localparam int ADC_BITS  = 12;                             // converter resolution
    localparam int PAD_BITS  = WORD_BITS - ADC_BITS;           // zero fill at the bottom

    // output code thresholds (two's complement)
    localparam logic signed [15:0] CODE_OVERFLOW   = 16'sh7F00; // 32512 and up
    localparam logic signed [15:0] CODE_NOM_POS    = 16'sh6C00; // 27648 full scale
    localparam logic signed [15:0] CODE_UPPER_MAX  = 16'sh7EFF; // 32511
    localparam logic signed [15:0] CODE_LOWER_MIN  = 16'sh8100; // -32512
    localparam logic signed [15:0] CODE_LIVE0_MIN  = 16'shE500; // -6912
    localparam logic        [15:0] DAC_ZERO_WORD   = 16'h0000;  // driven on out of range

    // output ranges
    typedef enum logic [1:0] {
        RNG_VOLT_BIP  = 2'h0,                                  // +-10 V
        RNG_CUR_BIP   = 2'h1,                                  // +-20 mA
        RNG_CUR_LIVE0 = 2'h2                                   // 4 to 20 mA
    } aio_range_t;

    // input scan states
    typedef enum logic [3:0] {
        IN_WAIT  = 4'h1,
        IN_BASIC = 4'h2,
        IN_CAL   = 4'h4,
        IN_PUSH  = 4'h8
    } aio_in_state_t;

    // output refresh states
    typedef enum logic [1:0] {
        OUT_FETCH = 2'h1,
        OUT_CONV  = 2'h2
    } aio_out_state_t;

    // true when a code is converted, false when the output is forced to zero
    function automatic logic aio_code_live(input logic signed [15:0] code,
                                           input aio_range_t rng);
        logic live;
        live = (code < CODE_OVERFLOW);
        if (rng == RNG_CUR_LIVE0)
            live = live && (code >= CODE_LIVE0_MIN);
        else
            live = live && (code >= CODE_LOWER_MIN);
        return live;
    endfunction
endpackage

// File: verilog/aio_fifo.sv
// small flip-flop fifo with valid/ready on both sides
module aio_fifo import aio_pkg::*; #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];   // storage, indexed by pointer
    logic [AW:0]      wr_ptr_reg;        // extra bit tells full from empty
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

    // storage write, no reset needed on data
    always_ff @(posedge mclk) begin
        if (push)
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end

    // pointers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule

// File: verilog/aio_scan_map.sv
// analog i/o control: input channel scan and output code range mapping
// Function
// - overflow code 32512 and up gives zero output
// - 27648 is full scale; upper overrange still converted
// - bipolar underflow at -32513 and below gives zero
// - 4-20 mA: codes below -6912 give zero
// - input channels converted strictly one after another
// - scan cycle is 0.5 ms per active channel
// - each slot: basic phase then calibration phase
// - interrupt cycle mode waits for time interrupt
// - output fetches code from memory, then converts
// - output refresh period equals output conversion time
// - values are 16-bit two's complement, sign bit 15
// - 12-bit result left-justified, low bits zero
module aio_scan_map import aio_pkg::*; #(
    parameter int NCH       = 4,                // number of input channels
    parameter int CONV_CYC  = IN_CONV_CYC,      // input slot length in cycles
    parameter int BASIC_CYC = IN_BASIC_CYC,     // basic phase length in cycles
    parameter int OCONV_CYC = OUT_CONV_CYC,     // output conversion length in cycles
    parameter int FIFO_DEPTH = 16               // words buffered toward the cpu
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    // configuration
    input  wire logic [NCH-1:0]         chan_enable,
    input  wire logic                   irq_cycle_mode,
    input  wire logic                   time_irq,
    // input converter
    output logic                        adc_convert,
    output logic                        adc_calib,
    output logic [$clog2(NCH)-1:0]      adc_chan,
    input  wire logic [ADC_BITS-1:0]    adc_sample,
    // measured values toward the cpu
    output logic                        cpu_valid,
    input  wire logic                   cpu_ready,
    output logic [WORD_BITS-1:0]        cpu_accumulator,
    output logic [$clog2(NCH)-1:0]      cpu_chan,
    // output codes from the cpu
    input  wire logic                   out_wr,
    input  wire logic [WORD_BITS-1:0]   out_code,
    input  wire logic [1:0]             out_range,
    // output converter
    output logic [WORD_BITS-1:0]        dac_word,
    output logic                        dac_zero,
    output logic                        dac_load
);
    localparam int CW = $clog2(NCH);
    localparam int SW = $clog2(CONV_CYC + 1);
    localparam int OW = $clog2(OCONV_CYC + 1);
    localparam logic [SW-1:0] SLOT_BASIC_END = SW'(BASIC_CYC - 1);
    localparam logic [SW-1:0] SLOT_CAL_END   = SW'(CONV_CYC - 2);
    localparam logic [OW-1:0] OUT_CONV_END   = OW'(OCONV_CYC - 2);

    // next active channel above cur, wrapping to the lowest active one
    function automatic logic [CW-1:0] next_chan(input logic [CW-1:0] cur,
                                                input logic [NCH-1:0] en);
        logic [CW-1:0] found;
        logic          hit;
        found = cur;
        hit   = 1'b0;
        for (int i = 1; i <= NCH; i++) begin
            if (!hit && en[(int'(cur) + i) % NCH]) begin
                found = CW'((int'(cur) + i) % NCH);
                hit   = 1'b1;
            end
        end
        return found;
    endfunction

    // ---------------- input scan ----------------
    aio_in_state_t     in_state_reg;     // one-hot scan state
    logic [SW-1:0]     slot_cnt_reg;     // cycles into the current slot
    logic [CW-1:0]     chan_reg;         // channel being converted
    logic [ADC_BITS-1:0] sample_reg;     // result caught at end of basic phase
    logic              irq_meta_reg;     // time interrupt synchroniser, first stage
    logic              irq_sync_reg;     // second stage
    logic              irq_prev_reg;     // for edge detect
    logic              irq_pend_reg;     // a time interrupt has arrived
    logic              any_en;           // at least one channel active
    logic              irq_edge;         // rising edge of time interrupt
    logic              push_ok;          // fifo takes the slot's result
    logic [CW-1:0]     nxt_chan;         // following channel in scan order
    logic              wrap;             // this slot closes a scan cycle
    logic              cycle_start;      // a new scan cycle begins now
    logic              may_start;        // mode allows a cycle to begin
    logic              fifo_ready;
    logic [WORD_BITS-1:0] push_word;     // value handed to the cpu

    assign any_en    = |chan_enable;
    assign irq_edge  = irq_sync_reg && !irq_prev_reg;
    assign nxt_chan  = next_chan(chan_reg, chan_enable);
    assign wrap      = (nxt_chan <= chan_reg);
    assign may_start = !irq_cycle_mode || irq_pend_reg;
    assign push_ok   = (in_state_reg == IN_PUSH) && fifo_ready;
    assign cycle_start = any_en && may_start &&
                         ((in_state_reg == IN_WAIT) || (push_ok && wrap));
    // left-justified 12-bit result, zero fill below
    assign push_word = {sample_reg, {PAD_BITS{1'b0}}};

    // time interrupt comes from outside the clock domain
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_meta_reg <= 1'b0;
            irq_sync_reg <= 1'b0;
            irq_prev_reg <= 1'b0;
        end else begin
            irq_meta_reg <= time_irq;
            irq_sync_reg <= irq_meta_reg;
            irq_prev_reg <= irq_sync_reg;
        end
    end

    // pending interrupt: a new edge wins over the consume in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            irq_pend_reg <= 1'b0;
        else
            irq_pend_reg <= (irq_pend_reg && !cycle_start) || irq_edge;
    end

    // scan state machine: one slot at a time, basic then calibration
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            in_state_reg <= IN_WAIT;
            slot_cnt_reg <= '0;
            chan_reg     <= CW'(NCH - 1);
        end else begin
            unique case (in_state_reg)
                IN_WAIT: begin
                    slot_cnt_reg <= '0;
                    if (cycle_start) begin
                        // start at the lowest active channel
                        chan_reg     <= next_chan(CW'(NCH - 1), chan_enable);
                        in_state_reg <= IN_BASIC;
                    end
                end
                IN_BASIC: begin
                    slot_cnt_reg <= slot_cnt_reg + 1'b1;
                    if (slot_cnt_reg == SLOT_BASIC_END)
                        in_state_reg <= IN_CAL;
                end
                IN_CAL: begin
                    slot_cnt_reg <= slot_cnt_reg + 1'b1;
                    if (slot_cnt_reg == SLOT_CAL_END)
                        in_state_reg <= IN_PUSH;
                end
                IN_PUSH: begin
                    // a full fifo stalls the scan, which stretches the cycle
                    if (push_ok) begin
                        slot_cnt_reg <= '0;
                        if (!any_en || (wrap && !cycle_start)) begin
                            in_state_reg <= IN_WAIT;
                        end else begin
                            // skip inactive channels, ascending order
                            chan_reg     <= nxt_chan;
                            in_state_reg <= IN_BASIC;
                        end
                    end
                end
            endcase
        end
    end

    // the converter result is taken as the basic phase ends
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            sample_reg <= '0;
        else if (in_state_reg == IN_BASIC && slot_cnt_reg == SLOT_BASIC_END)
            sample_reg <= adc_sample;
    end

    // state bits drive the converter directly, so only one phase is ever up
    assign adc_convert = in_state_reg[1];
    assign adc_calib   = in_state_reg[2];
    assign adc_chan    = chan_reg;

    // buffer toward the cpu; results leave one at a time in scan order
    aio_fifo #(
        .WIDTH (CW + WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .in_valid  (in_state_reg == IN_PUSH),
        .in_ready  (fifo_ready),
        .in_data   ({chan_reg, push_word}),
        .out_valid (cpu_valid),
        .out_ready (cpu_ready),
        .out_data  ({cpu_chan, cpu_accumulator})
    );

    // ---------------- output refresh ----------------
    aio_out_state_t       out_state_reg;   // fetch or convert
    logic [OW-1:0]        out_cnt_reg;     // cycles into conversion
    logic [WORD_BITS-1:0] mem_code_reg;    // code written by the cpu
    aio_range_t           mem_rng_reg;     // range written by the cpu
    logic signed [15:0]   conv_code_reg;   // code being converted, sign in bit 15
    aio_range_t           conv_rng_reg;
    logic [WORD_BITS-1:0] dac_word_reg;
    logic                 dac_zero_reg;
    logic                 dac_load_reg;
    logic                 conv_live;

    assign conv_live = aio_code_live(conv_code_reg, conv_rng_reg);

    // internal memory for the output code
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mem_code_reg <= '0;
            mem_rng_reg  <= RNG_VOLT_BIP;
        end else if (out_wr) begin
            mem_code_reg <= out_code;
            mem_rng_reg  <= aio_range_t'(out_range);
        end
    end

    // refresh: one fetch cycle then conversion, back to back forever
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_state_reg <= OUT_FETCH;
            out_cnt_reg   <= '0;
            conv_code_reg <= '0;
            conv_rng_reg  <= RNG_VOLT_BIP;
        end else begin
            unique case (out_state_reg)
                OUT_FETCH: begin
                    conv_code_reg <= signed'(mem_code_reg);
                    conv_rng_reg  <= mem_rng_reg;
                    out_cnt_reg   <= '0;
                    out_state_reg <= OUT_CONV;
                end
                OUT_CONV: begin
                    out_cnt_reg <= out_cnt_reg + 1'b1;
                    if (out_cnt_reg == OUT_CONV_END)
                        out_state_reg <= OUT_FETCH;
                end
            endcase
        end
    end

    // converter word: live codes pass as is, out-of-range forces zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dac_word_reg <= DAC_ZERO_WORD;
            dac_zero_reg <= 1'b1;
            dac_load_reg <= 1'b0;
        end else begin
            dac_load_reg <= (out_state_reg == OUT_CONV) && (out_cnt_reg == OUT_CONV_END);
            if (out_state_reg == OUT_CONV && out_cnt_reg == OUT_CONV_END) begin
                // the analog stage scales proportionally, overrange included
                dac_word_reg <= conv_live ? conv_code_reg : DAC_ZERO_WORD;
                dac_zero_reg <= !conv_live;
            end
        end
    end

    assign dac_word = dac_word_reg;
    assign dac_zero = dac_zero_reg;
    assign dac_load = dac_load_reg;

    // ---------------- checks ----------------
    localparam int OUT_PERIOD = OCONV_CYC;
    logic [OW:0] per_cnt_reg;      // cycles since the previous load
    logic        per_seen_reg;     // one load seen already

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            per_cnt_reg  <= '0;
            per_seen_reg <= 1'b0;
        end else begin
            per_cnt_reg  <= dac_load ? '0 : per_cnt_reg + 1'b1;
            per_seen_reg <= per_seen_reg || dac_load;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_basic_done;
        $fell(adc_convert);
    endsequence
    sequence s_cal_running;
        adc_calib && slot_cnt_reg == SW'(BASIC_CYC);
    endsequence

    ovf_zero_a: assert property (dac_load && conv_code_reg >= CODE_OVERFLOW |->
        dac_zero && dac_word == DAC_ZERO_WORD) else $error("overflow code not zeroed");
    upper_pass_a: assert property (dac_load && conv_code_reg >= CODE_NOM_POS &&
        conv_code_reg <= CODE_UPPER_MAX |-> !dac_zero && dac_word == conv_code_reg)
        else $error("upper range code not converted");
    under_zero_a: assert property (dac_load && conv_rng_reg != RNG_CUR_LIVE0 &&
        conv_code_reg < CODE_LOWER_MIN |-> dac_zero) else $error("underflow code not zeroed");
    live_zero_a: assert property (dac_load && conv_rng_reg == RNG_CUR_LIVE0 |->
        dac_zero == (conv_code_reg < CODE_LIVE0_MIN || conv_code_reg >= CODE_OVERFLOW))
        else $error("4-20 mA limit wrong");
    one_phase_a: assert property (!(adc_convert && adc_calib))
        else $error("two converter phases at once");
    phase_order_a: assert property (s_basic_done |-> s_cal_running)
        else $error("calibration does not follow basic phase");
    slot_len_a: assert property (adc_calib && slot_cnt_reg == SLOT_CAL_END |=>
        in_state_reg == IN_PUSH) else $error("slot length wrong");
    irq_wait_a: assert property ($rose(adc_convert) && irq_cycle_mode &&
        $past(in_state_reg) == IN_WAIT |-> $past(irq_pend_reg))
        else $error("cycle began without interrupt");
    fetch_conv_a: assert property (out_state_reg == OUT_FETCH |=>
        out_state_reg == OUT_CONV && conv_code_reg == $past(mem_code_reg))
        else $error("fetch did not precede conversion");
    refresh_a: assert property (dac_load && per_seen_reg |->
        per_cnt_reg == (OW + 1)'(OUT_PERIOD - 1)) else $error("refresh period wrong");
    left_just_a: assert property (cpu_valid |->
        cpu_accumulator[PAD_BITS-1:0] == '0) else $error("low bits not zero");
    asc_order_a: assert property (push_ok && !wrap && in_state_reg == IN_PUSH ##1
        adc_convert |-> adc_chan > $past(adc_chan) && chan_enable[adc_chan])
        else $error("scan order wrong");
endmodule

// File: testbench/aio_cpu_model.sv
// controller cpu model: takes measured words off the scan block's stream
module aio_cpu_model (
    // clock
    input  wire logic        mclk,
    // stall request from the bench
    input  wire logic        stall,
    // measured value stream
    input  wire logic        cpu_valid,
    output logic             cpu_ready,
    input  wire logic [15:0] cpu_accumulator,
    input  wire logic [1:0]  cpu_chan
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] got_q [$];  // words taken, channel above the value
    // ready moves only after a falling edge, so it is steady at every sampling edge
    always @(negedge mclk) begin
        cpu_ready <= !stall;
    end
    // a word counts only where valid and ready meet, one per edge
    always @(posedge mclk) begin
        if (cpu_valid === 1'b1 && cpu_ready === 1'b1) begin
            got_q.push_back({cpu_chan, cpu_accumulator});
        end
    end
endmodule

// File: testbench/tb_aio_scan_map.sv
// self-checking bench for the analog scan and output code map block
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_aio_scan_map import aio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV_P  = 50;  // shortened input slot
    localparam int BASIC_P = 40;  // shortened basic phase
    localparam int OCONV_P = 10;  // shortened output conversion
    logic        mclk, arst_n, irq_cycle_mode, time_irq, stall;
    logic [3:0]  chan_enable;
    logic        adc_convert, adc_calib, cpu_valid, cpu_ready, out_wr, dac_zero, dac_load;
    logic [1:0]  adc_chan, cpu_chan, out_range;
    logic [11:0] adc_sample;
    logic [15:0] cpu_accumulator, out_code, dac_word;
    int          error_cnt, cmp_count, cyc;
    aio_scan_map #(.NCH(4), .CONV_CYC(CONV_P), .BASIC_CYC(BASIC_P), .OCONV_CYC(OCONV_P),
        .FIFO_DEPTH(16)) aio_scan_map_inst (.mclk(mclk), .arst_n(arst_n),
        .chan_enable(chan_enable), .irq_cycle_mode(irq_cycle_mode), .time_irq(time_irq),
        .adc_convert(adc_convert), .adc_calib(adc_calib), .adc_chan(adc_chan),
        .adc_sample(adc_sample), .cpu_valid(cpu_valid), .cpu_ready(cpu_ready),
        .cpu_accumulator(cpu_accumulator), .cpu_chan(cpu_chan), .out_wr(out_wr),
        .out_code(out_code), .out_range(out_range), .dac_word(dac_word),
        .dac_zero(dac_zero), .dac_load(dac_load));
    aio_cpu_model aio_cpu_model_inst (.mclk(mclk), .stall(stall), .cpu_valid(cpu_valid),
        .cpu_ready(cpu_ready), .cpu_accumulator(cpu_accumulator), .cpu_chan(cpu_chan));
    // one compare, counted; case inequality so an unknown never matches
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic test_done;
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // channel that follows c in the enable pattern 1011
    function automatic logic [1:0] nxt(input logic [1:0] c);
        return (c == 2'h0) ? 2'h1 : (c == 2'h1) ? 2'h3 : 2'h0;
    endfunction
    // clock, cycle count and hang guard
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    // converter result tracks the channel so each word shows where it came from
    always @(negedge mclk) adc_sample <= {adc_chan, 10'h2B5};
    // basic and calibration phases never overlap
    always @(posedge mclk) if (arst_n === 1'b1) `CHK(adc_convert & adc_calib, 1'b0);
    // cycles up to the next output load, counted from the current phase
    task automatic wait_load(output int n);
        n = 0;
        do begin @(posedge mclk); #1; n++; end while (dac_load !== 1'b1 && n < 100);
    endtask
    // one input slot: channel, start cycle and the length of both phases
    task automatic slot(output int hi, output int cal, output logic [1:0] ch, output int t0);
        int k;
        hi = 0; cal = 0; k = 0;
        while (adc_convert !== 1'b1 && k < 400) begin @(posedge mclk); #1; k++; end
        t0 = cyc; ch = adc_chan;
        while (adc_convert === 1'b1 && hi < 400) begin hi++; @(posedge mclk); #1; end
        while (adc_calib === 1'b1 && cal < 400) begin cal++; @(posedge mclk); #1; end
    endtask
    // output codes at every range boundary, entries are {zero, range, code}
    task automatic out_map_test;
        int n;
        logic [18:0] tbl [10] = '{{3'h4, 16'h7F00}, {3'h0, 16'h7EFF}, {3'h2, 16'h6C00},
            {3'h0, 16'h8100}, {3'h5, 16'h80FF}, {3'h2, 16'hE500}, {3'h6, 16'hE4FF},
            {3'h6, 16'h8100}, {3'h2, 16'h0000}, {3'h2, 16'hFFFF}};
        for (int i = 0; i < 10; i++) begin
            @(negedge mclk);
            out_code = tbl[i][15:0]; out_range = tbl[i][17:16]; out_wr = 1'b1;
            @(negedge mclk);
            out_wr = 1'b0;
            wait_load(n);
            wait_load(n);  // the second load is sure to carry the new code
            `CHK(n, OCONV_P);
            `CHK(dac_zero, tbl[i][18]);
            `CHK(dac_word, tbl[i][18] ? 16'h0000 : tbl[i][15:0]);
        end
    endtask
    // scan over channels 0, 1 and 3 with the cpu always ready
    task automatic scan_test;
        int hi, cal, t0, tfirst;
        logic [1:0] ch;
        logic [17:0] w;
        logic [1:0] order [6] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h3};
        tfirst = 0;
        aio_cpu_model_inst.got_q.delete();
        @(negedge mclk);
        chan_enable = 4'b1011;  // channel 2 deactivated
        for (int i = 0; i < 6; i++) begin
            slot(hi, cal, ch, t0);
            if (i == 0) tfirst = t0;
            `CHK(ch, order[i]);
            `CHK(hi, BASIC_P);
            `CHK(cal, CONV_P - BASIC_P - 1);
            if (i == 3) `CHK(t0 - tfirst, 3 * CONV_P);
        end
        repeat (5) @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            w = aio_cpu_model_inst.got_q[i];
            `CHK(w, {order[i], order[i], 10'h2B5, 4'h0});
        end
    endtask
    // cpu stalls until the buffer refuses, then drains back to back
    task automatic fifo_test;
        int busy;
        logic [1:0] c;
        busy = 0;
        @(negedge mclk);
        // non-blocking so the model's falling-edge sample sees one settled value
        stall <= 1'b1;
        repeat (20 * CONV_P) @(posedge mclk);
        #1;
        `CHK(cpu_valid, 1'b1);
        repeat (2 * CONV_P) begin @(posedge mclk); #1; busy += adc_convert; end
        `CHK(busy, 0);
        aio_cpu_model_inst.got_q.delete();
        @(negedge mclk);
        stall <= 1'b0;
        repeat (40) @(posedge mclk);
        `CHK(aio_cpu_model_inst.got_q.size() >= 17, 1'b1);
        for (int i = 1; i < 17; i++) begin
            c = aio_cpu_model_inst.got_q[i - 1][17:16];
            `CHK(aio_cpu_model_inst.got_q[i][17:16], nxt(c));
        end
    endtask
    // interrupt cycle mode on one channel: no new cycle before the time interrupt
    task automatic irq_test;
        int hi, cal, t0, tirq, busy;
        logic [1:0] ch;
        busy = 0;
        @(negedge mclk);
        chan_enable = 4'b0001;
        irq_cycle_mode = 1'b1;
        repeat (5 * CONV_P) @(posedge mclk);
        repeat (4 * CONV_P) begin @(posedge mclk); #1; busy += adc_convert; end
        `CHK(busy, 0);
        @(negedge mclk);
        time_irq = 1'b1;
        tirq = cyc;
        repeat (4) @(negedge mclk);
        time_irq = 1'b0;
        slot(hi, cal, ch, t0);
        `CHK(t0 - tirq < 10, 1'b1);
        `CHK(ch, 2'h0);
        `CHK(hi, BASIC_P);
        busy = 0;
        repeat (3 * CONV_P) begin @(posedge mclk); #1; busy += adc_convert; end
        `CHK(busy, 0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        arst_n = 1'b0; irq_cycle_mode = 1'b0; time_irq = 1'b0; stall = 1'b0;
        chan_enable = 4'h0; out_wr = 1'b0;
        out_code = 16'h0000; out_range = 2'h0;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'b1;
        out_map_test();
        scan_test();
        fifo_test();
        irq_test();
        test_done();
    end
endmodule
